// File: test/pio_pins_model.sv
// pin model: open-drain port 0 and pulled-up ports 1 to 3
// assumes the bench drives pull_lo and the port 0 external level
`timescale 1ns/100ps
module pio_pins_model (
	// drive from the design, ports 3..0
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe_n,
	// external parties
	input wire logic [31:0] pull_lo,
	input wire logic [7:0] p0_ext,
	// resolved levels
	output logic [31:0] pin_lvl
);
	// a released quasi pin sits high; released port 0 shows whatever drives it outside
	assign pin_lvl = ~pull_lo & ((~pin_oe_n & pin_out) | (pin_oe_n & {24'hFF_FFFF, p0_ext}));
endmodule

// File: test/pio_port_logic_properties.sv
// port logic checker: pin drive, read paths, bus muxing and alternate inputs
// assumes it is bound to pio_port_logic and sees only its ports
`timescale 1ns/100ps
module pio_port_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// cpu side
	input wire pio_pkg::pio_op_e cpu_op,
	input wire logic [1:0] cpu_port,
	input wire logic [7:0] cpu_wdata,
	input wire logic [7:0] cpu_rdata,
	// bus side
	input wire logic bus_active,
	input wire logic bus_page_mode,
	input wire logic bus_addr_phase,
	input wire logic bus_hi_used,
	input wire logic [17:0] bus_addr,
	input wire logic bus_wr_n,
	// alternate inputs
	input wire logic serial_rx_in,
	input wire logic ext_irq_0_n,
	input wire logic ext_irq_1_n,
	input wire logic timer_zero_count_in,
	input wire logic timer_one_count_in,
	input wire logic [4:0] capture_pwm_pin_in,
	input wire logic [2:0] pulse_meas_in,
	// pins
	input wire logic [7:0] p0_out,
	input wire logic [7:0] p0_oe_n,
	input wire logic [7:0] p1_in,
	input wire logic [7:0] p1_oe_n,
	input wire logic [7:0] p2_in,
	input wire logic [7:0] p2_out,
	input wire logic [7:0] p2_oe_n,
	input wire logic [7:0] p3_in,
	input wire logic [7:0] p3_out,
	input wire logic [7:0] p3_oe_n
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// pin paths need three quiet edges: two through the sync flops, one into the registered read or alternate input
	sequence quiet3;
		!srst ##1 !srst ##1 !srst;
	endsequence
	sequence wr_p2;
		cpu_op == pio_pkg::op_write && cpu_port == pio_pkg::PORT_2 && !bus_active;
	endsequence
	reset_release_a: assert property ($fell(srst) |-> (p0_oe_n & p1_oe_n & p2_oe_n & p3_oe_n) == 8'h00FF)
		else $error("pins not released after reset");
	gpio_write_a: assert property (wr_p2 ##1 (cpu_op == pio_pkg::op_none && !bus_active)
		|=> p2_out == $past(cpu_wdata, 2) && p2_oe_n == $past(cpu_wdata, 2))
		else $error("port 2 pins do not follow write");
	rmw_latch_a: assert property (wr_p2 ##1 (cpu_port == pio_pkg::PORT_2 && cpu_op != pio_pkg::op_none
		&& cpu_op != pio_pkg::op_read_pin) |=> cpu_rdata == $past(cpu_wdata, 2))
		else $error("modify op did not read latch");
	read_pin_a: assert property (quiet3 ##0 (cpu_op == pio_pkg::op_read_pin && cpu_port == pio_pkg::PORT_2)
		|=> cpu_rdata == $past(p2_in, 3))
		else $error("pin read wrong");
	p0_drain_a: assert property (!bus_active |=> (p0_out & ~p0_oe_n) == 8'h0000)
		else $error("port 0 drives a one outside bus");
	bus_low_a: assert property (bus_active && (bus_addr_phase || bus_page_mode)
		|=> p0_out == $past(bus_addr[7:0]) && p0_oe_n == 8'h0000)
		else $error("port 0 lacks low address");
	bus_high_a: assert property (bus_active && !bus_page_mode && bus_hi_used
		|=> p2_out == $past(bus_addr[15:8]) && p2_oe_n == 8'h0000)
		else $error("port 2 lacks high address");
	wr_strobe_a: assert property (bus_active && !bus_wr_n |=> !p3_out[6] && !p3_oe_n[6])
		else $error("write strobe missing");
	p3_alt_in_a: assert property (quiet3 |=> {serial_rx_in, ext_irq_0_n, ext_irq_1_n, timer_zero_count_in,
		timer_one_count_in} == $past({p3_in[0], p3_in[2], p3_in[3], p3_in[4], p3_in[5]}, 3))
		else $error("port 3 alternate inputs wrong");
	p1_alt_in_a: assert property (quiet3 |=> pulse_meas_in == $past(p1_in[7:5], 3)
		&& capture_pwm_pin_in == $past(p1_in[7:3], 3))
		else $error("port 1 alternate inputs wrong");
endmodule

// File: test/pio_port_logic_test.sv
// self-checking bench for pio_port_logic with a pin model on the far side
// assumes one 250 MHz clock and a synchronous reset
`timescale 1ns/100ps
module pio_port_logic_test;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	pio_pkg::pio_op_e cpu_op = pio_pkg::op_none;
	logic [1:0] cpu_port = 2'h0;
	logic [2:0] cpu_bit = 3'h0;
	logic [7:0] cpu_wdata = 8'h0000, bus_wdata = 8'h0000, p1_alt_out = 8'h00FF, p3_alt_out = 8'h00FF;
	logic cpu_carry = 1'b0, bus_active = 1'b0, bus_page_mode = 1'b0, bus_addr_phase = 1'b0, bus_hi_used = 1'b0;
	logic bus_drive_data = 1'b0, bus_rd_n = 1'b1, bus_wr_n = 1'b1, bus_a17_en = 1'b0;
	logic [17:0] bus_addr = 18'h0_0000;
	pio_pkg::pio_p37_e bus_p37_mode = pio_pkg::p37_gpio;
	logic [7:0] cpu_rdata, bus_rdata, p0_out, p0_oe_n, p1_out, p1_oe_n, p2_out, p2_oe_n, p3_out, p3_oe_n;
	logic [7:0] p0_in, p1_in, p2_in, p3_in, p0_ext = 8'h00A5;
	logic cpu_bit_val, cpu_nonzero, serial_rx_in, ext_irq_0_n, ext_irq_1_n;
	logic timer_zero_count_in, timer_one_count_in, waveform_ext_clock_in;
	logic [4:0] capture_pwm_pin_in;
	logic [2:0] pulse_meas_in;
	logic [3:0] analog_input_level;
	logic [31:0] pull_lo = 32'h0000_0000, pin_lvl;
	int checks = 0;
	int fail_count = 0;
	always #2 core_clk = ~core_clk;
	pio_port_logic dut (.*);
	pio_pins_model pins (.pin_out({p3_out, p2_out, p1_out, p0_out}), .pin_oe_n({p3_oe_n, p2_oe_n, p1_oe_n, p0_oe_n}),
		.pull_lo(pull_lo), .p0_ext(p0_ext), .pin_lvl(pin_lvl));
	assign {p3_in, p2_in, p1_in, p0_in} = pin_lvl;
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task put(input pio_pkg::pio_op_e o, input logic [1:0] p, input logic [2:0] b, input logic [7:0] d);
		@(posedge core_clk);
		cpu_op <= o;
		cpu_port <= p;
		cpu_bit <= b;
		cpu_wdata <= d;
		cpu_carry <= ~d[b];
	endtask
	// dropping to idle here keeps one op per call, never a repeat
	task done;
		@(posedge core_clk);
		cpu_op <= pio_pkg::op_none;
		#1;
	endtask
	task op(input pio_pkg::pio_op_e o, input logic [1:0] p, input logic [2:0] b, input logic [7:0] d);
		put(o, p, b, d);
		done;
	endtask
	task bcyc(input logic [6:0] ctl);
		@(posedge core_clk);
		{bus_active, bus_page_mode, bus_addr_phase, bus_hi_used, bus_drive_data, bus_rd_n, bus_wr_n} <= ctl;
		@(posedge core_clk);
		#1;
	endtask
	task give_verdict;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		#1;
		cmp(p0_oe_n & p1_oe_n & p2_oe_n & p3_oe_n & p1_out & p2_out & p3_out, 8'h00FF);
		cmp(cpu_rdata | bus_rdata, 8'h0000);
		$display("t_reset done");
	endtask
	task t_rmw;
		logic [7:0] v, w, e;
		v = 8'h00A5;
		w = 8'h003C;
		for (int i = 4; i < 10; i++)
		begin
			case (i)
				4: e = v & w;
				5: e = v | w;
				6: e = v ^ w;
				7: e = v + 8'h0001;
				default: e = v - 8'h0001;
			endcase
			put(pio_pkg::op_write, pio_pkg::PORT_2, 3'h0, v);
			put(pio_pkg::pio_op_e'(i), pio_pkg::PORT_2, 3'h0, w);
			done;
			cmp(cpu_rdata, v);
			if (i == 9)
				cmp(cpu_nonzero, e != 8'h0000);
			op(pio_pkg::op_read_latch, pio_pkg::PORT_2, 3'h0, w);
			cmp(cpu_rdata, e);
			v = e + 8'h0011;
		end
		$display("t_rmw done");
	endtask
	task t_bits;
		logic [7:0] v, e;
		logic [2:0] b;
		v = 8'h0096;
		for (int i = 10; i < 15; i++)
		begin
			b = 3'(i - 8);
			e = v;
			e[b] = (i == 13 || i == 11 || i == 14) ? ~v[b] | (i == 13) : 1'b0;
			put(pio_pkg::op_write, 2'h3, b, v);
			put(pio_pkg::pio_op_e'(i), 2'h3, b, v);
			done;
			cmp(cpu_bit_val, v[b]);
			op(pio_pkg::op_read_latch, 2'h3, b, v);
			cmp(cpu_rdata, e);
		end
		$display("t_bits done");
	endtask
	task t_pins;
		@(posedge core_clk) pull_lo <= 32'h0030_0000;
		op(pio_pkg::op_write, pio_pkg::PORT_2, 3'h0, 8'h00F0);
		op(pio_pkg::op_write, pio_pkg::PORT_0, 3'h0, 8'h000F);
		repeat (4) @(posedge core_clk);
		#1;
		cmp(p2_oe_n, 8'h00F0);
		op(pio_pkg::op_read_pin, pio_pkg::PORT_2, 3'h0, 8'h0000);
		cmp(cpu_rdata, 8'h00C0);
		op(pio_pkg::op_read_latch, pio_pkg::PORT_2, 3'h0, 8'h0000);
		cmp(cpu_rdata, 8'h00F0);
		op(pio_pkg::op_read_pin, pio_pkg::PORT_0, 3'h0, 8'h0000);
		cmp(cpu_rdata, 8'h0005);
		$display("t_pins done");
	endtask
	task t_alt;
		@(posedge core_clk) pull_lo <= 32'h2900_5A00;
		op(pio_pkg::op_write, 2'h1, 3'h0, 8'h00FF);
		op(pio_pkg::op_write, 2'h3, 3'h0, 8'h00FF);
		@(posedge core_clk) p3_alt_out <= 8'h00FD;
		repeat (4) @(posedge core_clk);
		#1;
		cmp(p3_out, 8'h00FD);
		cmp({serial_rx_in, ext_irq_0_n, ext_irq_1_n, timer_zero_count_in, timer_one_count_in}, 8'h000A);
		cmp({capture_pwm_pin_in, pulse_meas_in}, 8'h00A5);
		cmp({waveform_ext_clock_in, analog_input_level}, 8'h0015);
		@(posedge core_clk) pull_lo <= 32'h0000_0000;
		@(posedge core_clk) p3_alt_out <= 8'h00FF;
		$display("t_alt done");
	endtask
	task t_bus;
		op(pio_pkg::op_write, pio_pkg::PORT_2, 3'h0, 8'h0081);
		@(posedge core_clk)
		begin
			bus_addr <= 18'h0_C35A;
			bus_wdata <= 8'h0069;
			bus_a17_en <= 1'b1;
			bus_p37_mode <= pio_pkg::p37_addr16;
			p0_ext <= 8'h003E;
		end
		bcyc(7'h5B);
		cmp(p0_out, 8'h005A);
		cmp(p2_out, 8'h00C3);
		cmp({p1_out[7], p3_out[7]}, 8'h0000);
		bcyc(7'h4E);
		cmp(p0_out, 8'h0069);
		cmp(p3_out[6], 8'h0000);
		@(posedge core_clk) bus_p37_mode <= pio_pkg::p37_rd_strobe;
		bcyc(7'h41);
		cmp(p0_oe_n, 8'h00FF);
		cmp(p2_out, 8'h0081);
		cmp(p3_out[7], 8'h0000);
		op(pio_pkg::op_write, pio_pkg::PORT_0, 3'h0, 8'h0000);
		repeat (2) @(posedge core_clk);
		#1;
		cmp(bus_rdata, 8'h003E);
		bcyc(7'h7B);
		cmp(p0_out, 8'h005A);
		cmp(p2_out, 8'h00C3);
		bcyc(7'h6E);
		cmp(p2_out, 8'h0069);
		cmp(p0_out, 8'h005A);
		@(posedge core_clk)
		begin
			bus_p37_mode <= pio_pkg::p37_gpio;
			pull_lo <= 32'h0012_0000;
		end
		bcyc(7'h69);
		cmp(p2_oe_n, 8'h00FF);
		cmp(p3_out[7], 8'h0001);
		repeat (3) @(posedge core_clk);
		#1;
		cmp(bus_rdata, 8'h00ED);
		bcyc(7'h03);
		op(pio_pkg::op_read_latch, pio_pkg::PORT_0, 3'h0, 8'h0000);
		cmp(cpu_rdata, 8'h00FF);
		op(pio_pkg::op_read_latch, pio_pkg::PORT_2, 3'h0, 8'h0000);
		cmp(cpu_rdata, 8'h0081);
		$display("t_bus done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		t_reset;
		t_rmw;
		t_bits;
		t_pins;
		t_alt;
		t_bus;
		give_verdict;
	end
	// the tests need well under a thousand cycles
	initial
	begin
		#20000;
		fail_count++;
		give_verdict;
	end
endmodule
bind pio_port_logic pio_port_checker chk (.*);

// File: verilog/pio_pkg.sv
// parallel port package: widths, reset values, pin positions, cpu port operations
// assumes a single core clock domain; used by pio_port_logic and pio_sync2
package pio_pkg;

	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 4;
	localparam int SYNC_STAGES = 2;

	// value after reset of every port latch, and the fill forced into port 0 for bus cycles
	localparam logic [7:0] LATCH_RST = 8'h00FF;
	localparam logic [7:0] BUS_P0_FILL = 8'h00FF;
	localparam logic [7:0] ONE_BYTE = 8'h0001;
	localparam logic [7:0] ZERO_BYTE = 8'h0000;

	// port numbers
	localparam logic [1:0] PORT_0 = 2'h0;
	localparam logic [1:0] PORT_2 = 2'h2;

	// port 3 alternate function positions
	localparam int P3_SER_RX_BIT = 0;
	localparam int P3_SER_TX_BIT = 1;
	localparam int P3_IRQ0_BIT = 2;
	localparam int P3_IRQ1_BIT = 3;
	localparam int P3_T0_BIT = 4;
	localparam int P3_T1_BIT = 5;
	localparam int P3_WR_BIT = 6;
	localparam int P3_RD_BIT = 7;

	// port 1 alternate function positions
	localparam int P1_ANALOG_LSB = 0;
	localparam int P1_WAVE_CLK_BIT = 2;
	localparam int P1_CAPTURE_LSB = 3;
	localparam int P1_PULSE_LSB = 5;
	localparam int P1_A17_BIT = 7;

	// external address bit positions
	localparam int ADDR_W = 18;
	localparam int ADDR_A16_BIT = 16;
	localparam int ADDR_A17_BIT = 17;

	// cpu port operations
	typedef enum logic [3:0] {
		op_none = 4'h0,
		op_write = 4'h1,
		op_read_pin = 4'h2,
		op_read_latch = 4'h3,
		and_into_op = 4'h4,
		or_into_op = 4'h5,
		xor_into_op = 4'h6,
		op_increment = 4'h7,
		subtract_one_op = 4'h8,
		count_down_loop_op = 4'h9,
		test_clear_jump_op = 4'hA,
		invert_bit_op = 4'hB,
		op_bit_clear = 4'hC,
		op_bit_set = 4'hD,
		op_bit_move_carry = 4'hE
	} pio_op_e;

	// use of port 3 bit 7 during bus cycles
	typedef enum logic [1:0] {
		p37_gpio = 2'b00,
		p37_rd_strobe = 2'b01,
		p37_addr16 = 2'b10
	} pio_p37_e;

endpackage

// File: verilog/pio_port_logic.sv
// four 8-bit bidirectional parallel ports: latches, read paths, alternate functions, bus muxing
// assumes the cpu core, peripherals and bus sequencer run on core_clk; pins are asynchronous
//
// Functional notes
// R1: each port bit is a d latch loaded by the cpu write strobe for that port
// R2: two read paths: stored latch value, or synchronised pin level
// R3: every pin is configured as input or output on its own
// R4: latch one releases the pull-down so the pin can be an input
// R5: ports 1 and 3 with latch one follow the peripheral alternate output
// R6: in bus cycles port 0 drives address/data lines, not the latch; port 2 does so only with bus_hi_used or in page-mode data phases
// R7: ports 0 and 2 give no general-purpose output while acting as bus
// R8: port 0 drives ones only in bus cycles; otherwise open-drain
// R9: port 2 carries address 15:8, or address/data 15:8 in page mode
// R10: port 3 bit 7 is read strobe or address 16; port 1 bit 7 address 17
// R11: port 3 bit 6 is the active-low external write strobe
// R12: port 3 bits 0-5: serial rx, tx, two irqs, two timer inputs
// R13: port 1: analog 0-3 on bits 0-3, wave clock bit 2, capture 0-4 bits 3-7
// R14: port 1 bits 5, 6, 7 are pulse measurement inputs 0, 1, 2
// R15: logic, increment, decrement and jump operations read the latch, not the pin
// R16: bit move, clear, set read all latch bits, change one, write the byte
// R17: reset loads ones into all four latches, releasing all pins
// R18: port 0 carries address 7:0 with data, or address only in page mode
// R19: port 0 latch loads all ones for bus cycles; port 2 latch is kept
// R20: plain reads return the pin level
`timescale 1ns/100ps
module pio_port_logic (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// cpu port operations
	input wire pio_pkg::pio_op_e cpu_op,
	input wire logic [1:0] cpu_port,
	input wire logic [2:0] cpu_bit,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_carry,
	output logic [7:0] cpu_rdata,
	output logic cpu_bit_val,
	output logic cpu_nonzero,
	// external memory bus
	input wire logic bus_active,
	input wire logic bus_page_mode,
	input wire logic bus_addr_phase,
	input wire logic bus_hi_used,
	input wire logic [17:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_drive_data,
	input wire logic bus_rd_n,
	input wire logic bus_wr_n,
	input wire logic bus_a17_en,
	input wire pio_pkg::pio_p37_e bus_p37_mode,
	output logic [7:0] bus_rdata,
	// peripheral alternate outputs
	input wire logic [7:0] p1_alt_out,
	input wire logic [7:0] p3_alt_out,
	// peripheral alternate inputs
	output logic serial_rx_in,
	output logic ext_irq_0_n,
	output logic ext_irq_1_n,
	output logic timer_zero_count_in,
	output logic timer_one_count_in,
	output logic waveform_ext_clock_in,
	output logic [4:0] capture_pwm_pin_in,
	output logic [2:0] pulse_meas_in,
	output logic [3:0] analog_input_level,
	// port 0 pins
	input wire logic [7:0] p0_in,
	output logic [7:0] p0_out,
	output logic [7:0] p0_oe_n,
	// port 1 pins
	input wire logic [7:0] p1_in,
	output logic [7:0] p1_out,
	output logic [7:0] p1_oe_n,
	// port 2 pins
	input wire logic [7:0] p2_in,
	output logic [7:0] p2_out,
	output logic [7:0] p2_oe_n,
	// port 3 pins
	input wire logic [7:0] p3_in,
	output logic [7:0] p3_out,
	output logic [7:0] p3_oe_n
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [7:0] pin_raw [0:3];
	logic [7:0] pin_s [0:3];

	assign pin_raw[0] = p0_in;
	assign pin_raw[1] = p1_in;
	assign pin_raw[2] = p2_in;
	assign pin_raw[3] = p3_in;

	genvar gi;
	generate
		for (gi = 0; gi < pio_pkg::NUM_PORTS; gi++)
		begin : g_sync
			pio_sync2 u_sync (
				.core_clk(core_clk),
				.srst(srst),
				.async_in(pin_raw[gi]),
				.sync_out(pin_s[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// cpu operation decode

	logic [7:0] port_latch_reg [0:3];
	logic [7:0] src_latch;
	logic [7:0] bit_mask;
	logic [7:0] op_result;
	logic [7:0] op_rdata;
	logic op_wr;

	always_comb
	begin
		src_latch = port_latch_reg[cpu_port];
		bit_mask = pio_pkg::ONE_BYTE << cpu_bit;
		op_result = src_latch;
		op_rdata = src_latch; // R2
		op_wr = 1'b1;
		case (cpu_op)
			pio_pkg::op_write:
				op_result = cpu_wdata;
			pio_pkg::op_read_pin:
			begin
				op_rdata = pin_s[cpu_port]; // R20 R2
				op_wr = 1'b0;
			end
			pio_pkg::and_into_op:
				op_result = src_latch & cpu_wdata; // R15
			pio_pkg::or_into_op:
				op_result = src_latch | cpu_wdata; // R15
			pio_pkg::xor_into_op:
				op_result = src_latch ^ cpu_wdata; // R15
			pio_pkg::op_increment:
				op_result = src_latch + pio_pkg::ONE_BYTE; // R15
			pio_pkg::subtract_one_op, pio_pkg::count_down_loop_op:
				op_result = src_latch - pio_pkg::ONE_BYTE; // R15
			pio_pkg::test_clear_jump_op, pio_pkg::op_bit_clear:
				op_result = src_latch & ~bit_mask; // R15 R16
			pio_pkg::invert_bit_op:
				op_result = src_latch ^ bit_mask; // R15
			pio_pkg::op_bit_set:
				op_result = src_latch | bit_mask; // R16
			pio_pkg::op_bit_move_carry:
				op_result = cpu_carry ? (src_latch | bit_mask) : (src_latch & ~bit_mask); // R16
			// latch read, idle and unused codes leave the latch alone
			default:
				op_wr = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// port latches

	// port 0 bus fill wins over a cpu write in the same cycle, so the bus never sees stale data
	always_ff @(posedge core_clk)
	begin
		for (int i = 0; i < pio_pkg::NUM_PORTS; i++)
		begin
			if (srst)
				port_latch_reg[i] <= pio_pkg::LATCH_RST; // R17
			else if (i == 0 && bus_active)
				port_latch_reg[i] <= pio_pkg::BUS_P0_FILL; // R19
			else if (op_wr && cpu_port == 2'(i))
				port_latch_reg[i] <= op_result; // R1 R3
		end
	end

	// read data holds until the next operation
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			cpu_rdata <= pio_pkg::ZERO_BYTE;
			cpu_bit_val <= 1'b0;
			cpu_nonzero <= 1'b0;
		end
		else if (cpu_op != pio_pkg::op_none)
		begin
			cpu_rdata <= op_rdata;
			cpu_bit_val <= src_latch[cpu_bit]; // R15
			cpu_nonzero <= (op_result != pio_pkg::ZERO_BYTE);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drive, next values

	logic [7:0] p0_out_nxt;
	logic [7:0] p0_oe_n_nxt;
	logic [7:0] p1_out_nxt;
	logic [7:0] p1_oe_n_nxt;
	logic [7:0] p2_out_nxt;
	logic [7:0] p2_oe_n_nxt;
	logic [7:0] p3_out_nxt;
	logic [7:0] p3_oe_n_nxt;
	logic [7:0] p1_alt;
	logic [7:0] p3_alt;

	// port 0: strong bus drive, open-drain otherwise
	always_comb
	begin
		p0_out_nxt = port_latch_reg[0];
		p0_oe_n_nxt = port_latch_reg[0]; // R4 R8
		if (bus_active)
		begin
			p0_out_nxt = (bus_addr_phase || bus_page_mode) ? bus_addr[7:0] : bus_wdata; // R6 R18
			p0_oe_n_nxt = pio_pkg::LATCH_RST;
			if (bus_addr_phase || bus_page_mode || bus_drive_data)
				p0_oe_n_nxt = pio_pkg::ZERO_BYTE; // R7 R8
		end
	end

	// port 2: latch shows on the pins unless a page-mode data phase or bus_hi_used puts bus bits there
	always_comb
	begin
		p2_out_nxt = port_latch_reg[2];
		p2_oe_n_nxt = port_latch_reg[2]; // R4
		if (bus_active && !bus_addr_phase && bus_page_mode)
		begin
			p2_out_nxt = bus_wdata; // R9
			p2_oe_n_nxt = bus_drive_data ? pio_pkg::ZERO_BYTE : pio_pkg::LATCH_RST; // R7
		end
		else if (bus_active && bus_hi_used)
		begin
			p2_out_nxt = bus_addr[15:8]; // R6 R9
			p2_oe_n_nxt = pio_pkg::ZERO_BYTE; // R7
		end
	end

	// ports 1 and 3: quasi-bidirectional, only a low is driven; the pull-up is outside
	always_comb
	begin
		p1_alt = p1_alt_out;
		p3_alt = p3_alt_out;
		if (bus_active && bus_a17_en)
			p1_alt[pio_pkg::P1_A17_BIT] = bus_addr[pio_pkg::ADDR_A17_BIT]; // R10
		if (bus_active)
		begin
			p3_alt[pio_pkg::P3_WR_BIT] = bus_wr_n; // R11
			case (bus_p37_mode)
				pio_pkg::p37_rd_strobe:
					p3_alt[pio_pkg::P3_RD_BIT] = bus_rd_n; // R10
				pio_pkg::p37_addr16:
					p3_alt[pio_pkg::P3_RD_BIT] = bus_addr[pio_pkg::ADDR_A16_BIT]; // R10
				default:
					p3_alt[pio_pkg::P3_RD_BIT] = p3_alt_out[pio_pkg::P3_RD_BIT];
			endcase
		end
		p1_out_nxt = port_latch_reg[1] & p1_alt; // R5
		p3_out_nxt = port_latch_reg[3] & p3_alt; // R5 R12
		p1_oe_n_nxt = p1_out_nxt; // R4 R3
		p3_oe_n_nxt = p3_out_nxt; // R4 R3
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered pin outputs

	// latch reset value releases every pin from the first edge
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			p0_out <= pio_pkg::LATCH_RST;
			p0_oe_n <= pio_pkg::LATCH_RST; // R17
			p1_out <= pio_pkg::LATCH_RST;
			p1_oe_n <= pio_pkg::LATCH_RST;
			p2_out <= pio_pkg::LATCH_RST;
			p2_oe_n <= pio_pkg::LATCH_RST;
			p3_out <= pio_pkg::LATCH_RST;
			p3_oe_n <= pio_pkg::LATCH_RST;
		end
		else
		begin
			p0_out <= p0_out_nxt;
			p0_oe_n <= p0_oe_n_nxt;
			p1_out <= p1_out_nxt;
			p1_oe_n <= p1_oe_n_nxt;
			p2_out <= p2_out_nxt;
			p2_oe_n <= p2_oe_n_nxt;
			p3_out <= p3_out_nxt;
			p3_oe_n <= p3_oe_n_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus read data and alternate inputs

	always_ff @(posedge core_clk)
	begin
		if (srst)
			bus_rdata <= pio_pkg::ZERO_BYTE;
		else
			bus_rdata <= bus_page_mode ? pin_s[2] : pin_s[0]; // R9 R18
	end

	// analog levels here are digital samples only; the converter taps the pad itself
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			serial_rx_in <= 1'b1;
			ext_irq_0_n <= 1'b1;
			ext_irq_1_n <= 1'b1;
			timer_zero_count_in <= 1'b1;
			timer_one_count_in <= 1'b1;
			waveform_ext_clock_in <= 1'b1;
			capture_pwm_pin_in <= 5'h1F;
			pulse_meas_in <= 3'h7;
			analog_input_level <= 4'hF;
		end
		else
		begin
			serial_rx_in <= pin_s[3][pio_pkg::P3_SER_RX_BIT]; // R12
			ext_irq_0_n <= pin_s[3][pio_pkg::P3_IRQ0_BIT]; // R12
			ext_irq_1_n <= pin_s[3][pio_pkg::P3_IRQ1_BIT]; // R12
			timer_zero_count_in <= pin_s[3][pio_pkg::P3_T0_BIT]; // R12
			timer_one_count_in <= pin_s[3][pio_pkg::P3_T1_BIT]; // R12
			waveform_ext_clock_in <= pin_s[1][pio_pkg::P1_WAVE_CLK_BIT]; // R13
			capture_pwm_pin_in <= pin_s[1][pio_pkg::P1_CAPTURE_LSB +: 5]; // R13
			pulse_meas_in <= pin_s[1][pio_pkg::P1_PULSE_LSB +: 3]; // R14
			analog_input_level <= pin_s[1][pio_pkg::P1_ANALOG_LSB +: 4]; // R13
		end
	end

endmodule

// File: verilog/pio_sync2.sv
// two flip-flop synchroniser for one 8-bit group of pin inputs
// assumes the inputs are asynchronous to core_clk
`timescale 1ns/100ps
module pio_sync2 (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// data
	input wire logic [7:0] async_in,
	output logic [7:0] sync_out
);

	logic [7:0] meta_r;

	// first stage is read by the second stage only
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			meta_r <= pio_pkg::LATCH_RST;
			sync_out <= pio_pkg::LATCH_RST;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule
